/* File: rtl/psda_pkg.sv */
// Notes on behaviour
// [R1] Table address is table_page above the 16-bit effective_addr, 24 bits.
// [R2] table_page bit 7 clear reaches user memory, set reaches configuration memory.
// [R3] Window address is visibility_page joined with effective_addr 14:0, bit 23 zero.
// [R4] Window ignores effective_addr bit 15; address bit 15 is visibility_page bit 0.
// [R5] Data goes to program memory only if effective_addr bit 15 and enable set.
// [R6] Window covers data 8000h upward, mapped onto one of 256 16K-word pages.
// [R7] Program counter steps two per program word; low and high spaces share addresses.
// [R8] table_read_low word mode returns program bits 15:0 whole.
// [R9] table_read_low byte mode returns upper byte if select 1, else lower.
// [R10] table_read_high word mode returns bits 23:16 low, zero upper byte.
// [R11] table_read_high byte mode returns zero when phantom byte selected.
// [R12] Only table high instructions reach bits 23:16; window gives low 16 bits.
// [R13] Window mapping is suspended during table reads and writes.
// [R14] Window data read takes one added cycle for a second fetch.
// [R15] Outside repeat: move adds one cycle, other instructions add two.
// [R16] In repeat: edges and interrupt exit or re-entry add two, else none.
// [R17] Software fills unused upper bytes of window data with all ones or zeros.
// [R18] Byte select is effective_addr bit 0.
// [R19] Fetch address has bit 23 zero, bits 22:1 from counter, bit 0 zero.
package psda_pkg;

	localparam logic [7:0]  PSDA_OFS_TABLE_PAGE  = 8'h00;
	localparam logic [7:0]  PSDA_OFS_VIS_PAGE    = 8'h04;
	localparam logic [7:0]  PSDA_OFS_CORE_CTRL   = 8'h08;
	localparam logic [7:0]  PSDA_OFS_STATUS      = 8'h0C;

	localparam logic [7:0]  PSDA_TABLE_PAGE_RST  = 8'h00;
	localparam logic [7:0]  PSDA_VIS_PAGE_RST    = 8'h00;
	localparam logic [15:0] PSDA_CORE_CTRL_RST   = 16'h0000;

	localparam int          PSDA_WIN_EN_BIT      = 2;
	localparam int          PSDA_EA_WIN_BIT      = 15;
	localparam int          PSDA_CFG_BIT         = 7;

	localparam logic [1:0]  PSDA_EXTRA_MOVE      = 2'h1;
	localparam logic [1:0]  PSDA_EXTRA_OTHER     = 2'h2;
	localparam logic [1:0]  PSDA_EXTRA_REP_EDGE  = 2'h2;
	localparam logic [1:0]  PSDA_EXTRA_REP_MID   = 2'h0;

	typedef enum logic [2:0] {
		PSDA_OP_NONE,
		PSDA_OP_FETCH,
		PSDA_OP_DATA_READ,
		PSDA_OP_TRD_LOW,
		PSDA_OP_TRD_HIGH,
		PSDA_OP_TWR_LOW,
		PSDA_OP_TWR_HIGH
	} psda_op_t;

	typedef enum logic [1:0] {
		PSDA_CLS_MOVE,
		PSDA_CLS_DMOVE,
		PSDA_CLS_OTHER
	} psda_cls_t;

	typedef enum logic [2:0] {
		PSDA_ST_IDLE,
		PSDA_ST_RD,
		PSDA_ST_RD2,
		PSDA_ST_CAP,
		PSDA_ST_WAIT,
		PSDA_ST_WR
	} psda_st_t;

	typedef struct packed {
		psda_op_t    op;
		psda_cls_t   cls;
		logic        byte_mode;
		logic [15:0] effective_addr;
		logic [23:0] pc;
		logic [15:0] wdata;
		logic        in_repeat;
		logic [3:0]  repeat_edge;
	} psda_req_t;

	typedef struct packed {
		logic        done;
		logic        from_prog;
		logic [23:0] rdata;
	} psda_rsp_t;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic        cfg;
		logic [23:0] addr;
		logic [23:0] wdata;
		logic [2:0]  wmask;
	} psda_mem_t;

	typedef struct packed {
		psda_st_t    st;
		psda_op_t    op;
		logic        bmode;
		logic [15:0] ea;
		logic [1:0]  extra;
		logic        win;
		logic        last_cfg;
		logic        last_win;
		logic [7:0]  tpage;
		logic [7:0]  vpage;
		logic [15:0] core_control_reg;
		logic        ack;
		logic [31:0] dat;
		psda_mem_t   mem;
		psda_rsp_t   rsp;
	} psda_state_t;

endpackage : psda_pkg

/* File: rtl/psda_core.sv */
// Our own choices: the address map and the Wishbone slave port.
`timescale 1ns/1ns
module psda_core (
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [7:0]          wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output      logic [31:0]         wb_dat_o,
	output      logic                wb_ack_o,
	input  wire psda_pkg::psda_req_t req_i,
	output      logic                busy_o,
	output      psda_pkg::psda_rsp_t rsp_o,
	output      psda_pkg::psda_mem_t mem_o,
	input  wire logic [23:0]         prog_rdata_i
);

	psda_pkg::psda_state_t r_reg;
	psda_pkg::psda_state_t r_next;

	logic                  take;
	logic                  win_hit;
	logic [1:0]            extra;
	logic                  bsel;
	logic                  is_table;

	assign busy_o   = (r_reg.st != psda_pkg::PSDA_ST_IDLE);
	assign wb_ack_o = r_reg.ack;
	assign wb_dat_o = r_reg.dat;
	assign rsp_o    = r_reg.rsp;
	assign mem_o    = r_reg.mem;
	assign take     = !busy_o && (req_i.op != psda_pkg::PSDA_OP_NONE);
	assign bsel     = r_reg.ea[0]; // R18
	assign is_table = (r_reg.op == psda_pkg::PSDA_OP_TRD_LOW) ||
	                  (r_reg.op == psda_pkg::PSDA_OP_TRD_HIGH) ||
	                  (r_reg.op == psda_pkg::PSDA_OP_TWR_LOW) ||
	                  (r_reg.op == psda_pkg::PSDA_OP_TWR_HIGH);

	// Only plain data reads can hit the window, so table ops never map through it
	assign win_hit = (req_i.op == psda_pkg::PSDA_OP_DATA_READ) &&
	                 req_i.effective_addr[psda_pkg::PSDA_EA_WIN_BIT] &&
	                 r_reg.core_control_reg[psda_pkg::PSDA_WIN_EN_BIT]; // R5 R6 R13

	always_comb begin
		if (req_i.in_repeat) begin
			// Mid-loop iterations are pipelined, so no second fetch is paid
			extra = (req_i.repeat_edge != 4'h0) ? psda_pkg::PSDA_EXTRA_REP_EDGE
			                                    : psda_pkg::PSDA_EXTRA_REP_MID; // R16
		end else if (req_i.cls == psda_pkg::PSDA_CLS_OTHER) begin
			extra = psda_pkg::PSDA_EXTRA_OTHER; // R15
		end else begin
			extra = psda_pkg::PSDA_EXTRA_MOVE; // R15
		end
	end

	always_comb begin
		r_next          = r_reg;
		r_next.ack      = 1'b0;
		r_next.mem.rd   = 1'b0;
		r_next.mem.wr   = 1'b0;
		r_next.rsp.done = 1'b0;

		if (wb_cyc_i && wb_stb_i && !r_reg.ack) begin
			r_next.ack = 1'b1;
			r_next.dat = 32'h00000000;
			if (wb_adr_i == psda_pkg::PSDA_OFS_TABLE_PAGE) begin
				r_next.dat = {24'h000000, r_reg.tpage};
				if (wb_we_i && wb_sel_i[0]) begin
					r_next.tpage = wb_dat_i[7:0];
				end
			end else if (wb_adr_i == psda_pkg::PSDA_OFS_VIS_PAGE) begin
				r_next.dat = {24'h000000, r_reg.vpage};
				if (wb_we_i && wb_sel_i[0]) begin
					r_next.vpage = wb_dat_i[7:0];
				end
			end else if (wb_adr_i == psda_pkg::PSDA_OFS_CORE_CTRL) begin
				r_next.dat = {16'h0000, r_reg.core_control_reg};
				if (wb_we_i && wb_sel_i[0]) begin
					r_next.core_control_reg[7:0] = wb_dat_i[7:0];
				end
				if (wb_we_i && wb_sel_i[1]) begin
					r_next.core_control_reg[15:8] = wb_dat_i[15:8];
				end
			end else if (wb_adr_i == psda_pkg::PSDA_OFS_STATUS) begin
				r_next.dat = {28'h0000000, r_reg.last_win, r_reg.last_cfg,
				              busy_o && is_table, busy_o};
			end
		end

		case (r_reg.st)
			psda_pkg::PSDA_ST_IDLE: begin
				if (take) begin
					r_next.op    = req_i.op;
					r_next.bmode = req_i.byte_mode;
					r_next.ea    = req_i.effective_addr;
					r_next.win   = win_hit;
					r_next.extra = win_hit ? extra : 2'h0;
					r_next.mem.cfg = 1'b0;
					case (req_i.op)
						psda_pkg::PSDA_OP_FETCH: begin
							r_next.st       = psda_pkg::PSDA_ST_RD;
							r_next.mem.rd   = 1'b1;
							r_next.mem.addr = {1'b0, req_i.pc[22:1], 1'b0}; // R19 R7
						end
						psda_pkg::PSDA_OP_DATA_READ: begin
							if (win_hit) begin
								r_next.st       = psda_pkg::PSDA_ST_RD;
								r_next.mem.rd   = 1'b1;
								r_next.mem.addr = {1'b0, r_reg.vpage,
								                   req_i.effective_addr[14:0]}; // R3 R4
								r_next.last_win = 1'b1;
							end else begin
								r_next.rsp.done      = 1'b1; // R5
								r_next.rsp.from_prog = 1'b0;
								r_next.rsp.rdata     = 24'h000000;
								r_next.last_win      = 1'b0;
							end
						end
						psda_pkg::PSDA_OP_TRD_LOW,
						psda_pkg::PSDA_OP_TRD_HIGH: begin
							r_next.st       = psda_pkg::PSDA_ST_RD;
							r_next.mem.rd   = 1'b1;
							r_next.mem.addr = {r_reg.tpage, req_i.effective_addr}; // R1
							r_next.mem.cfg  = r_reg.tpage[psda_pkg::PSDA_CFG_BIT]; // R2
							r_next.last_cfg = r_reg.tpage[psda_pkg::PSDA_CFG_BIT];
						end
						default: begin
							r_next.st       = psda_pkg::PSDA_ST_WR;
							r_next.mem.wr   = 1'b1;
							r_next.mem.addr = {r_reg.tpage, req_i.effective_addr}; // R1
							r_next.mem.cfg  = r_reg.tpage[psda_pkg::PSDA_CFG_BIT]; // R2
							r_next.last_cfg = r_reg.tpage[psda_pkg::PSDA_CFG_BIT];
							if (req_i.op == psda_pkg::PSDA_OP_TWR_HIGH) begin
								r_next.mem.wdata = {req_i.wdata[7:0], 16'h0000}; // R12
								// Phantom byte writes are dropped
								r_next.mem.wmask = (req_i.byte_mode &&
								                    req_i.effective_addr[0]) ? 3'h0 : 3'h4;
							end else if (!req_i.byte_mode) begin
								r_next.mem.wdata = {8'h00, req_i.wdata};
								r_next.mem.wmask = 3'h3;
							end else if (req_i.effective_addr[0]) begin
								r_next.mem.wdata = {8'h00, req_i.wdata[7:0], 8'h00}; // R18
								r_next.mem.wmask = 3'h2;
							end else begin
								r_next.mem.wdata = {16'h0000, req_i.wdata[7:0]};
								r_next.mem.wmask = 3'h1;
							end
						end
					endcase
				end
			end
			psda_pkg::PSDA_ST_RD: begin
				if (r_reg.extra != 2'h0) begin
					// Window word needs a second array fetch
					r_next.st     = psda_pkg::PSDA_ST_RD2;
					r_next.mem.rd = 1'b1; // R14
					r_next.extra  = r_reg.extra - 2'h1;
				end else begin
					r_next.st = psda_pkg::PSDA_ST_CAP;
				end
			end
			psda_pkg::PSDA_ST_RD2: begin
				r_next.st = psda_pkg::PSDA_ST_CAP;
			end
			psda_pkg::PSDA_ST_CAP: begin
				r_next.rsp.from_prog = 1'b1;
				case (r_reg.op)
					psda_pkg::PSDA_OP_TRD_LOW: begin
						if (!r_reg.bmode) begin
							r_next.rsp.rdata = {8'h00, prog_rdata_i[15:0]}; // R8
						end else if (bsel) begin
							r_next.rsp.rdata = {16'h0000, prog_rdata_i[15:8]}; // R9
						end else begin
							r_next.rsp.rdata = {16'h0000, prog_rdata_i[7:0]}; // R9
						end
					end
					psda_pkg::PSDA_OP_TRD_HIGH: begin
						if (r_reg.bmode && bsel) begin
							r_next.rsp.rdata = 24'h000000; // R11
						end else begin
							r_next.rsp.rdata = {16'h0000, prog_rdata_i[23:16]}; // R10 R11
						end
					end
					psda_pkg::PSDA_OP_DATA_READ: begin
						r_next.rsp.rdata = {8'h00, prog_rdata_i[15:0]}; // R12
					end
					default: begin
						r_next.rsp.rdata = prog_rdata_i;
					end
				endcase
				if (r_reg.extra == 2'h0) begin
					r_next.rsp.done = 1'b1;
					r_next.st       = psda_pkg::PSDA_ST_IDLE;
				end else begin
					r_next.st = psda_pkg::PSDA_ST_WAIT;
				end
			end
			psda_pkg::PSDA_ST_WAIT: begin
				r_next.extra = r_reg.extra - 2'h1; // R15
				if (r_reg.extra == 2'h1) begin
					r_next.rsp.done = 1'b1;
					r_next.st       = psda_pkg::PSDA_ST_IDLE;
				end
			end
			psda_pkg::PSDA_ST_WR: begin
				r_next.rsp.done      = 1'b1;
				r_next.rsp.from_prog = 1'b0;
				r_next.st            = psda_pkg::PSDA_ST_IDLE;
			end
			default: begin
				r_next.st = psda_pkg::PSDA_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r_reg        <= '0;
			r_reg.st     <= psda_pkg::PSDA_ST_IDLE;
			r_reg.op     <= psda_pkg::PSDA_OP_NONE;
			r_reg.tpage  <= psda_pkg::PSDA_TABLE_PAGE_RST;
			r_reg.vpage  <= psda_pkg::PSDA_VIS_PAGE_RST;
			r_reg.core_control_reg <= psda_pkg::PSDA_CORE_CTRL_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_win_take;
		take && win_hit;
	endsequence

	sequence s_win_move;
		s_win_take ##0 !req_i.in_repeat && (req_i.cls != psda_pkg::PSDA_CLS_OTHER);
	endsequence

	sequence s_win_other;
		s_win_take ##0 !req_i.in_repeat && (req_i.cls == psda_pkg::PSDA_CLS_OTHER);
	endsequence

	sequence s_two_fetch;
		mem_o.rd ##1 mem_o.rd;
	endsequence

	property p_table_addr;
		take && (req_i.op == psda_pkg::PSDA_OP_TRD_LOW) |=>
			mem_o.addr == {$past(r_reg.tpage), $past(req_i.effective_addr)};
	endproperty
	a_table_addr: assert property (p_table_addr) else $error("table address wrong"); // R1

	property p_table_cfg;
		(mem_o.rd || mem_o.wr) && is_table |-> mem_o.cfg == mem_o.addr[23];
	endproperty
	a_table_cfg: assert property (p_table_cfg) else $error("config select wrong"); // R2

	property p_win_addr;
		s_win_take |=> mem_o.rd && !mem_o.addr[23] && (mem_o.addr[15] == r_reg.vpage[0]);
	endproperty
	a_win_addr: assert property (p_win_addr) else $error("window address wrong"); // R3

	property p_no_win;
		take && (req_i.op == psda_pkg::PSDA_OP_DATA_READ) && !win_hit |=>
			rsp_o.done && !rsp_o.from_prog && !busy_o;
	endproperty
	a_no_win: assert property (p_no_win) else $error("data read went to program"); // R5

	property p_trdh_word;
		rsp_o.done && (r_reg.op == psda_pkg::PSDA_OP_TRD_HIGH) |->
			rsp_o.rdata[23:8] == 16'h0000;
	endproperty
	a_trdh_word: assert property (p_trdh_word) else $error("phantom byte not zero"); // R10

	property p_trdl_word;
		(r_reg.st == psda_pkg::PSDA_ST_CAP) && (r_reg.op == psda_pkg::PSDA_OP_TRD_LOW) &&
			!r_reg.bmode |=> rsp_o.rdata[15:0] == $past(prog_rdata_i[15:0]);
	endproperty
	a_trdl_word: assert property (p_trdl_word) else $error("low word read wrong"); // R8

	property p_win_move;
		s_win_move |=> s_two_fetch ##1 !rsp_o.done ##1 rsp_o.done;
	endproperty
	a_win_move: assert property (p_win_move) else $error("move window timing wrong"); // R14

	property p_win_other;
		s_win_other |=> s_two_fetch ##1 !rsp_o.done[*2] ##1 rsp_o.done;
	endproperty
	a_win_other: assert property (p_win_other) else $error("window timing wrong"); // R15

	property p_rep_mid;
		s_win_take ##0 req_i.in_repeat && (req_i.repeat_edge == 4'h0) |=>
			mem_o.rd ##1 !mem_o.rd ##1 rsp_o.done;
	endproperty
	a_rep_mid: assert property (p_rep_mid) else $error("repeat timing wrong"); // R16

	property p_fetch_addr;
		take && (req_i.op == psda_pkg::PSDA_OP_FETCH) |=>
			!mem_o.addr[23] && !mem_o.addr[0] && mem_o.rd;
	endproperty
	a_fetch_addr: assert property (p_fetch_addr) else $error("fetch address wrong"); // R19

	property p_wr_no_win;
		mem_o.wr |-> !r_reg.win;
	endproperty
	a_wr_no_win: assert property (p_wr_no_win) else $error("window during table op"); // R13

	property p_win_page;
		s_win_take |=> (mem_o.addr[22:15] == $past(r_reg.vpage)) &&
			(mem_o.addr[14:0] == $past(req_i.effective_addr[14:0]));
	endproperty
	a_win_page: assert property (p_win_page) else $error("window page bits wrong"); // R4 R6

	property p_trdl_byte;
		(r_reg.st == psda_pkg::PSDA_ST_CAP) && (r_reg.op == psda_pkg::PSDA_OP_TRD_LOW) &&
			r_reg.bmode |=> rsp_o.rdata == {16'h0000, ($past(r_reg.ea[0]) ?
			$past(prog_rdata_i[15:8]) : $past(prog_rdata_i[7:0]))};
	endproperty
	a_trdl_byte: assert property (p_trdl_byte) else $error("low byte read wrong"); // R9

	property p_trdh_phantom;
		(r_reg.st == psda_pkg::PSDA_ST_CAP) && (r_reg.op == psda_pkg::PSDA_OP_TRD_HIGH) &&
			r_reg.bmode && bsel |=> rsp_o.rdata == 24'h000000;
	endproperty
	a_trdh_phantom: assert property (p_trdh_phantom) else $error("phantom read wrong"); // R11

	property p_rep_edge;
		s_win_take ##0 req_i.in_repeat && (req_i.repeat_edge != 4'h0) |=>
			s_two_fetch ##1 !rsp_o.done[*2] ##1 rsp_o.done;
	endproperty
	a_rep_edge: assert property (p_rep_edge) else $error("repeat edge timing"); // R16

	// High writes must leave the low word lanes alone
	property p_twr_high_lane;
		mem_o.wr && (r_reg.op == psda_pkg::PSDA_OP_TWR_HIGH) |->
			(mem_o.wmask[1:0] == 2'h0) && (mem_o.wdata[15:0] == 16'h0000);
	endproperty
	a_twr_high_lane: assert property (p_twr_high_lane) else $error("high lanes"); // R12

	property p_twr_low_lane;
		mem_o.wr && (r_reg.op == psda_pkg::PSDA_OP_TWR_LOW) |-> !mem_o.wmask[2];
	endproperty
	a_twr_low_lane: assert property (p_twr_low_lane) else $error("low lanes"); // R12

endmodule : psda_core

/* File: sim/psda_prog_mem.sv */
`timescale 1ns/1ns
module psda_prog_mem (
	input  wire logic                clk_i,
	input  wire psda_pkg::psda_mem_t mem_i,
	output      logic [23:0]         prog_rdata_o
);
	// Whole 24-bit word per address, low and high spaces together
	// Valid only in the cycle after rd; inverted on each cycle without rd, so stale data matches again every second cycle
	always_ff @(posedge clk_i) begin
		if (mem_i.rd) begin
			prog_rdata_o <= {mem_i.addr[7:0], mem_i.addr[23:8]};
		end else begin
			prog_rdata_o <= ~prog_rdata_o;
		end
	end
endmodule : psda_prog_mem

/* File: sim/psda_core_tb_top.sv */
`timescale 1ns/1ns
module psda_core_tb_top;
	typedef struct packed {
		psda_pkg::psda_op_t  op;
		psda_pkg::psda_cls_t cls;
		logic                bm;
		logic [15:0]         ea;
		logic                rep;
		logic [3:0]          edg;
		logic [23:0]         ad;
		logic [2:0]          k;
		logic [2:0]          n;
	} psda_row_t;
	localparam psda_pkg::psda_op_t  TRL = psda_pkg::PSDA_OP_TRD_LOW;
	localparam psda_pkg::psda_op_t  TRH = psda_pkg::PSDA_OP_TRD_HIGH;
	localparam psda_pkg::psda_op_t  DR  = psda_pkg::PSDA_OP_DATA_READ;
	localparam psda_pkg::psda_cls_t MV  = psda_pkg::PSDA_CLS_MOVE;
	localparam psda_pkg::psda_cls_t OT  = psda_pkg::PSDA_CLS_OTHER;
	logic                clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, busy_o;
	logic [7:0]          wb_adr_i;
	logic [3:0]          wb_sel_i;
	logic [31:0]         wb_dat_i, wb_dat_o, q;
	logic [23:0]         prog_rdata_i, d, a;
	logic                fp, cf;
	logic [23:0]         w;
	logic [2:0]          m;
	int                  n, err_total, samples_checked;
	psda_pkg::psda_req_t req_i;
	psda_pkg::psda_rsp_t rsp_o;
	psda_pkg::psda_mem_t mem_o;
	psda_row_t           rows[16];

	psda_core u_psda_core (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .req_i(req_i),
		.busy_o(busy_o), .rsp_o(rsp_o), .mem_o(mem_o), .prog_rdata_i(prog_rdata_i));
	psda_prog_mem u_psda_prog_mem (.clk_i(clk_i), .mem_i(mem_o), .prog_rdata_o(prog_rdata_i));

	initial begin
		clk_i = 1'h0;
		forever #20 clk_i = ~clk_i;
	end

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : summarize

	// Classic cycle: hold until ack seen at an edge, release at the following edge
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
		int t;
		@(posedge clk_i);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= wd;
		t = 0;
		do begin
			@(posedge clk_i);
			#1;
			t++;
		end while (wb_ack_o !== 1'h1 && t < 50);
		if (t >= 50) begin
			err_total++;
			summarize();
		end
		@(posedge clk_i);
		q = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		wb_we_i <= 1'h0;
	endtask : wb

	// Op dropped at the taking edge so the request is not taken twice
	task automatic run(input psda_row_t r);
		bit seen;
		@(posedge clk_i);
		req_i <= '{r.op, r.cls, r.bm, r.ea, {8'hC0, r.ea}, 16'h5A5A, r.rep, r.edg};
		n = 0;
		seen = 0;
		do begin
			@(posedge clk_i);
			if (n == 0) req_i.op <= psda_pkg::PSDA_OP_NONE;
			n++;
			#1;
			if ((mem_o.rd || mem_o.wr) && !seen) begin
				seen = 1;
				a = mem_o.addr;
				cf = mem_o.cfg;
				w = mem_o.wdata;
				m = mem_o.wmask;
			end
		end while (rsp_o.done !== 1'h1 && n < 20);
		d = rsp_o.rdata;
		fp = rsp_o.from_prog;
	endtask : run

	function automatic logic [23:0] xp(input psda_row_t r);
		logic [23:0] v;
		v = {r.ad[7:0], r.ad[23:8]};
		case (r.k)
			3'h0: return {8'h00, v[15:0]};
			3'h1: return {16'h0000, v[15:8]};
			3'h2: return {16'h0000, v[7:0]};
			3'h3: return {16'h0000, v[23:16]};
			3'h4: return 24'h000000;
			default: return v;
		endcase
	endfunction : xp

	initial begin
		#(40 * 4000);
		err_total++;
		summarize();
	end

	initial begin
		rows = '{
			'{TRL, OT, 1'h0, 16'h4A6C, 1'h0, 4'h0, 24'h124A6C, 3'h0, 3'h3},
			'{TRL, OT, 1'h1, 16'h4A6D, 1'h0, 4'h0, 24'h124A6D, 3'h1, 3'h3},
			'{TRL, OT, 1'h1, 16'h4A6C, 1'h0, 4'h0, 24'h124A6C, 3'h2, 3'h3},
			'{TRH, OT, 1'h0, 16'h4A6C, 1'h0, 4'h0, 24'h124A6C, 3'h3, 3'h3},
			'{TRH, OT, 1'h1, 16'h4A6D, 1'h0, 4'h0, 24'h124A6D, 3'h4, 3'h3},
			'{TRH, OT, 1'h1, 16'h4A6C, 1'h0, 4'h0, 24'h124A6C, 3'h3, 3'h3},
			'{TRL, OT, 1'h0, 16'hC123, 1'h0, 4'h0, 24'h12C123, 3'h0, 3'h3},
			'{DR, MV, 1'h0, 16'hC1FF, 1'h0, 4'h0, 24'h1AC1FF, 3'h0, 3'h4},
			'{DR, psda_pkg::PSDA_CLS_DMOVE, 1'h0, 16'h8000, 1'h0, 4'h0, 24'h1A8000, 3'h0, 3'h4},
			'{DR, OT, 1'h0, 16'hFFFF, 1'h0, 4'h0, 24'h1AFFFF, 3'h0, 3'h5},
			'{DR, MV, 1'h0, 16'hC1FF, 1'h1, 4'h1, 24'h1AC1FF, 3'h0, 3'h5},
			'{DR, MV, 1'h0, 16'hC1FF, 1'h1, 4'h8, 24'h1AC1FF, 3'h0, 3'h5},
			'{DR, MV, 1'h0, 16'hC1FF, 1'h1, 4'h0, 24'h1AC1FF, 3'h0, 3'h3},
			'{DR, MV, 1'h0, 16'h7FFE, 1'h0, 4'h0, 24'h000000, 3'h0, 3'h1},
			'{psda_pkg::PSDA_OP_FETCH, OT, 1'h0, 16'hABCD, 1'h0, 4'h0, 24'h40ABCC, 3'h5, 3'h3},
			'{psda_pkg::PSDA_OP_TWR_LOW, OT, 1'h0, 16'h0102, 1'h0, 4'h0, 24'h120102, 3'h0, 3'h2}
		};
		err_total = 0;
		samples_checked = 0;
		rst_i = 1'h1;
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h00000000;
		req_i = '0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'h0;
		for (int j = 0; j < 3; j++) begin
			wb(1'h0, 8'(j * 4), 32'h0);
			chk("reset value", q, 32'h0);
		end
		wb(1'h1, psda_pkg::PSDA_OFS_TABLE_PAGE, 32'h12);
		wb(1'h1, psda_pkg::PSDA_OFS_VIS_PAGE, 32'h35);
		wb(1'h1, psda_pkg::PSDA_OFS_CORE_CTRL, 32'hA504);
		wb(1'h1, 8'h10, 32'hFF);
		wb(1'h0, 8'h10, 32'h0);
		chk("unmapped read", q, 32'h0);
		wb(1'h0, psda_pkg::PSDA_OFS_VIS_PAGE, 32'h0);
		chk("visibility_page", q, 32'h35);
		wb(1'h0, psda_pkg::PSDA_OFS_CORE_CTRL, 32'h0);
		chk("core control", q, 32'h0000A504);
		foreach (rows[i]) begin
			run(rows[i]);
			chk("cycles", n, rows[i].n);
			if (rows[i].n != 1) chk("prog addr", a, rows[i].ad);
			chk("from_prog", fp, rows[i].n > 2);
			if (rows[i].n > 2) chk("rdata", d, xp(rows[i]));
		end
		// Top page bit selects configuration space
		wb(1'h1, psda_pkg::PSDA_OFS_TABLE_PAGE, 32'h92);
		run(rows[0]);
		chk("config addr", a, 24'h924A6C);
		chk("config space", cf, 1'h1);
		// Table writes: lanes follow instruction and byte select
		run(rows[15]);
		chk("low word data", w, 24'h005A5A);
		chk("low word lanes", m, 3'h3);
		run('{psda_pkg::PSDA_OP_TWR_HIGH, OT, 1'h0, 16'h0102, 1'h0, 4'h0, 24'h0, 3'h0, 3'h2});
		chk("high word data", w, 24'h5A0000);
		chk("high word lanes", m, 3'h4);
		chk("high word addr", a, 24'h920102);
		run('{psda_pkg::PSDA_OP_TWR_LOW, OT, 1'h1, 16'h0103, 1'h0, 4'h0, 24'h0, 3'h0, 3'h2});
		chk("low byte data", w, 24'h005A00);
		chk("low byte lanes", m, 3'h2);
		run('{psda_pkg::PSDA_OP_TWR_HIGH, OT, 1'h1, 16'h0103, 1'h0, 4'h0, 24'h0, 3'h0, 3'h2});
		chk("phantom lanes", m, 3'h0);
		chk("write cycles", n, 2);
		wb(1'h0, psda_pkg::PSDA_OFS_STATUS, 32'h0);
		chk("status", q, 32'h4);
		// Window closed: upper data addresses stay in data RAM
		wb(1'h1, psda_pkg::PSDA_OFS_CORE_CTRL, 32'h0);
		run(rows[7]);
		chk("closed cycles", n, 1);
		chk("closed from_prog", fp, 1'h0);
		// Reset in mid-run returns table_page and core control to zero
		@(posedge clk_i);
		rst_i <= 1'h1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'h0;
		wb(1'h0, psda_pkg::PSDA_OFS_TABLE_PAGE, 32'h0);
		chk("table_page after reset", q, 32'h0);
		wb(1'h0, psda_pkg::PSDA_OFS_CORE_CTRL, 32'h0);
		chk("core control after reset", q, 32'h0);
		summarize();
	end
endmodule : psda_core_tb_top
